// ### dcr_pkg.sv
// Purpose: shared constants of the four-channel synthesizer register bank
// Assumes: register addresses are 5-bit word addresses from the serial port controller
// Notes:   per-channel words sit in a 7-entry table indexed by address minus first offset
package dcr_pkg;
   localparam int          DCR_NCH       = 4;         // documented channel count
   localparam int          DCR_AW        = 5;         // register address width
   localparam int          DCR_NREG      = 7;         // per-channel words 0x03..0x09
   // register addresses
   localparam logic [4:0]  DCR_A_CSEL    = 5'h00;     // channel_selection_register
   localparam logic [4:0]  DCR_A_CFW     = 5'h03;     // channel_function_word
   localparam logic [4:0]  DCR_A_FTW     = 5'h04;     // frequency_tuning_word
   localparam logic [4:0]  DCR_A_POW     = 5'h05;     // phase_offset_word
   localparam logic [4:0]  DCR_A_ACW     = 5'h06;     // amplitude_control_word
   localparam logic [4:0]  DCR_A_SRR     = 5'h07;     // sweep_ramp_rate
   localparam logic [4:0]  DCR_A_RISE    = 5'h08;     // sweep_rising_step
   localparam logic [4:0]  DCR_A_FALL    = 5'h09;     // sweep_falling_step
   // table indices (address minus first channel address)
   localparam logic [2:0]  DCR_I_CFW     = 3'h0;
   localparam logic [2:0]  DCR_I_FTW     = 3'h1;
   localparam logic [2:0]  DCR_I_POW     = 3'h2;
   localparam logic [2:0]  DCR_I_ACW     = 3'h3;
   localparam logic [2:0]  DCR_I_SRR     = 3'h4;
   localparam logic [2:0]  DCR_I_RISE    = 3'h5;
   localparam logic [2:0]  DCR_I_FALL    = 3'h6;
   // field positions
   localparam int          DCR_B_CLRPH   = 1;         // phase accumulator clearing bit
   localparam int          DCR_B_AMPRATE = 16;        // amplitude ramp rate, bits 23:16
   localparam int          DCR_B_RRATE   = 0;         // rising ramp rate, bits 7:0
   localparam int          DCR_B_FRATE   = 8;         // falling ramp rate, bits 15:8
   localparam int          DCR_B_CHEN    = 4;         // channel enables, bits 7:4
   localparam int          DCR_B_LSBF    = 0;         // serial lsb-first bit
   localparam int          DCR_B_SMODE   = 1;         // serial mode, bits 2:1
   // writable-bit masks; open bits stay zero
   localparam logic [DCR_NREG-1:0][31:0] DCR_MASK = {
      32'hFFFFFFFF,  // falling step
      32'hFFFFFFFF,  // rising step
      32'h0000FFFF,  // ramp rates
      32'h00FFDFFF,  // amplitude control, bit 13 open
      32'h00003FFF,  // phase offset, bits 15:14 open
      32'hFFFFFFFF,  // tuning word
      32'h00C0E7FF}; // function word, 21:16 and 12:11 open
   localparam logic [DCR_NREG-1:0][31:0] DCR_RST = {
      32'h00000000, 32'h00000000, 32'h00000000, 32'h00000000,
      32'h00000000, 32'h00000000, 32'h00000302};
   localparam logic [7:0]  DCR_CSEL_MASK = 8'hF7;     // bit 3 must stay 0
   localparam logic [7:0]  DCR_CSEL_RST  = 8'hF0;
endpackage

// ### dcr_chan.sv
// Purpose: one channel copy of the per-channel registers, written and active sets
// Assumes: write strobe already qualified by channel enable and address range
// Notes:   read port shows the written set, outputs show the active set
`timescale 1ns/10ps
module dcr_chan (
   input  wire logic                                   clk,
   input  wire logic                                   rst_n,
   input  wire logic                                   wr_en,
   input  wire logic [2:0]                             wr_idx,
   input  wire logic [31:0]                            wr_data,
   input  wire logic                                   upd,
   input  wire logic [2:0]                             rd_idx,
   output logic      [31:0]                            rd_data,
   output logic      [dcr_pkg::DCR_NREG-1:0][31:0]     act,
   output logic                                        clr_pulse
);
   logic [dcr_pkg::DCR_NREG-1:0][31:0] pend_q, pend_d, act_q, act_d;
   logic                               clr_q, clr_d;

   // next values: writes land in the held set, an update copies it to the active set
   always_comb begin
      pend_d = pend_q;
      act_d  = act_q;
      clr_d  = 1'b0;
      if (wr_en) begin
         pend_d[wr_idx] = wr_data & dcr_pkg::DCR_MASK[wr_idx]; // R12
      end
      if (upd) begin
         act_d = pend_d; // R10
         clr_d = pend_d[dcr_pkg::DCR_I_CFW][dcr_pkg::DCR_B_CLRPH];
         act_d[dcr_pkg::DCR_I_CFW][dcr_pkg::DCR_B_CLRPH] = 1'b0; // R3
         // a write of 1 in the update cycle survives in the held set
         if (!(wr_en && wr_idx == dcr_pkg::DCR_I_CFW && wr_data[dcr_pkg::DCR_B_CLRPH])) begin
            pend_d[dcr_pkg::DCR_I_CFW][dcr_pkg::DCR_B_CLRPH] = 1'b0; // R3
         end
      end
   end

   // both sets come out of reset at their defaults, clearing bit set
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         pend_q <= dcr_pkg::DCR_RST; // R2
         act_q  <= dcr_pkg::DCR_RST; // R2
         clr_q  <= 1'b0;
      end else begin
         pend_q <= pend_d;
         act_q  <= act_d;
         clr_q  <= clr_d;
      end
   end

   assign rd_data   = (rd_idx < 3'(dcr_pkg::DCR_NREG)) ? pend_q[rd_idx] : 32'h00000000;
   assign act       = act_q;
   assign clr_pulse = clr_q;
endmodule // dcr_chan

// ### dcr_bank.sv
// Purpose: per-channel register bank of a four-channel synthesizer with channel select
// Assumes: serial port controller delivers whole decoded register writes and reads
// Notes:   channel enables act at once, every other bit waits for IO_UPDATE
// Operation
// R1: four copies, writes reach enabled channels only
// R2: clearing bit reads one after reset
// R3: IO update returns clearing bit to zero
// R4: 32-bit tuning word at 0x04
// R5: 14-bit phase offset, top two bits open
// R6: ramp rates: rising low byte, falling high
// R7: 32-bit rising step word at 0x08
// R8: 32-bit falling step word at 0x09
// R9: amplitude ramp rate in bits 23:16
// R10: new contents act only after IO update
// R11: channel enables act immediately after write
// R12: open bits read zero; undefined resets
`timescale 1ns/10ps
module dcr_bank #(
   parameter int NCH = dcr_pkg::DCR_NCH
) (
   input  wire logic                  CLK,
   input  wire logic                  RST_N,
   input  wire logic                  WR_STB,
   input  wire logic [4:0]            WR_ADDR,
   input  wire logic [31:0]           WR_DATA,
   input  wire logic                  RD_STB,
   input  wire logic [4:0]            RD_ADDR,
   output logic      [31:0]           RD_DATA,
   output logic                       RD_VALID,
   input  wire logic                  IO_UPDATE,
   output logic      [3:0]            CH_EN,
   output logic      [1:0]            SERIAL_MODE,
   output logic                       LSB_FIRST,
   output logic      [NCH-1:0][23:0]  CFW,
   output logic      [NCH-1:0][31:0]  FTW,
   output logic      [NCH-1:0][13:0]  POW,
   output logic      [NCH-1:0][23:0]  ACW,
   output logic      [NCH-1:0][7:0]   AMP_RATE,
   output logic      [NCH-1:0][7:0]   RISE_RATE,
   output logic      [NCH-1:0][7:0]   FALL_RATE,
   output logic      [NCH-1:0][31:0]  RISE_STEP,
   output logic      [NCH-1:0][31:0]  FALL_STEP,
   output logic      [NCH-1:0]        ACC_CLR
);
   // the selection byte has only four enable bits
   if (NCH < 1 || NCH > 4) begin : g_chk
      $error("NCH must be 1 to 4");
   end

   // true for an address inside the per-channel table
   function automatic logic is_chan(input logic [4:0] a);
      return (a >= dcr_pkg::DCR_A_CFW) && (a <= dcr_pkg::DCR_A_FALL);
   endfunction

   // table index of a per-channel address
   function automatic logic [2:0] chan_idx(input logic [4:0] a);
      logic [4:0] d;
      d = a - dcr_pkg::DCR_A_CFW;
      return d[2:0];
   endfunction

   logic [3:0]  en_q, en_d;
   logic [2:0]  cpend_q, cpend_d, cact_q, cact_d;
   logic [31:0] rdat_q, rdat_d;
   logic        rval_q, rval_d;
   logic        csel_wr, chan_wr;
   logic [NCH-1:0][31:0] ch_rd;
   logic [NCH-1:0][dcr_pkg::DCR_NREG-1:0][31:0] ch_act;

   assign csel_wr = WR_STB && (WR_ADDR == dcr_pkg::DCR_A_CSEL);
   assign chan_wr = WR_STB && is_chan(WR_ADDR);

   // selection register: enables bypass the update, mode bits wait for it
   always_comb begin
      logic [7:0] w;
      w       = WR_DATA[7:0] & dcr_pkg::DCR_CSEL_MASK;
      en_d    = en_q;
      cpend_d = cpend_q;
      cact_d  = cact_q;
      if (csel_wr) begin
         en_d    = w[dcr_pkg::DCR_B_CHEN +: 4]; // R11
         cpend_d = w[2:0];
      end
      if (IO_UPDATE) begin
         cact_d = cpend_d; // R10
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         en_q    <= dcr_pkg::DCR_CSEL_RST[dcr_pkg::DCR_B_CHEN +: 4];
         cpend_q <= dcr_pkg::DCR_CSEL_RST[2:0];
         cact_q  <= dcr_pkg::DCR_CSEL_RST[2:0];
      end else begin
         en_q    <= en_d;
         cpend_q <= cpend_d;
         cact_q  <= cact_d;
      end
   end

   // one copy per channel, each written only while its enable is set
   for (genvar i = 0; i < NCH; i++) begin : g_ch
      dcr_chan u_chan (
         .clk       (CLK),
         .rst_n     (RST_N),
         .wr_en     (chan_wr && en_q[i]), // R1
         .wr_idx    (chan_idx(WR_ADDR)),
         .wr_data   (WR_DATA),
         .upd       (IO_UPDATE),
         .rd_idx    (chan_idx(RD_ADDR)),
         .rd_data   (ch_rd[i]),
         .act       (ch_act[i]),
         .clr_pulse (ACC_CLR[i])
      );
      assign CFW[i]       = ch_act[i][dcr_pkg::DCR_I_CFW][23:0];
      assign FTW[i]       = ch_act[i][dcr_pkg::DCR_I_FTW]; // R4
      assign POW[i]       = ch_act[i][dcr_pkg::DCR_I_POW][13:0]; // R5
      assign ACW[i]       = ch_act[i][dcr_pkg::DCR_I_ACW][23:0];
      assign AMP_RATE[i]  = ch_act[i][dcr_pkg::DCR_I_ACW][dcr_pkg::DCR_B_AMPRATE +: 8]; // R9
      assign RISE_RATE[i] = ch_act[i][dcr_pkg::DCR_I_SRR][dcr_pkg::DCR_B_RRATE +: 8]; // R6
      assign FALL_RATE[i] = ch_act[i][dcr_pkg::DCR_I_SRR][dcr_pkg::DCR_B_FRATE +: 8]; // R6
      assign RISE_STEP[i] = ch_act[i][dcr_pkg::DCR_I_RISE]; // R7
      assign FALL_STEP[i] = ch_act[i][dcr_pkg::DCR_I_FALL]; // R8
   end

   // read: copies share an address, so the lowest enabled channel answers
   always_comb begin
      rdat_d = rdat_q;
      rval_d = RD_STB;
      if (RD_STB) begin
         rdat_d = 32'h00000000; // unmapped and all-disabled read as zero
         if (RD_ADDR == dcr_pkg::DCR_A_CSEL) begin
            rdat_d = {24'h000000, en_q, 1'b0, cpend_q};
         end else if (is_chan(RD_ADDR)) begin
            for (int i = NCH - 1; i >= 0; i--) begin
               if (en_q[i]) begin
                  rdat_d = ch_rd[i];
               end
            end
         end
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         rdat_q <= 32'h00000000;
         rval_q <= 1'b0;
      end else begin
         rdat_q <= rdat_d;
         rval_q <= rval_d;
      end
   end

   assign RD_DATA     = rdat_q;
   assign RD_VALID    = rval_q;
   assign CH_EN       = en_q;
   assign SERIAL_MODE = cact_q[dcr_pkg::DCR_B_SMODE +: 2];
   assign LSB_FIRST   = cact_q[dcr_pkg::DCR_B_LSBF];

   // per-channel checks use channel 0, which every channel count has; the hold check spans all channels
   default clocking dcr_cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   csel_immediate_a: assert property (csel_wr |=> CH_EN == $past(WR_DATA[7:4])) // R11
      else $error("channel enables did not follow selection write");
   clear_after_reset_a: assert property ($rose(RST_N) |-> CFW[0][1] == 1'b1) // R2
      else $error("clearing bit not set after reset");
   update_clears_a: assert property (IO_UPDATE |=> CFW[0][1] == 1'b0) // R3
      else $error("clearing bit not returned to zero by update");
   hold_no_update_a: assert property (!IO_UPDATE |=> $stable(FTW) && $stable(POW) && $stable(SERIAL_MODE)) // R10
      else $error("active word changed without update");
   ftw_load_a: assert property ((chan_wr && en_q[0] && WR_ADDR == dcr_pkg::DCR_A_FTW && IO_UPDATE)
                               |=> FTW[0] == $past(WR_DATA)) // R4
      else $error("tuning word not loaded");
   // the held copy is watched, since an update may legally move the active one
   disabled_skip_a: assert property ((chan_wr && !en_q[0] && WR_ADDR == dcr_pkg::DCR_A_RISE)
                                    |=> $stable(g_ch[0].u_chan.pend_q[dcr_pkg::DCR_I_RISE])) // R1
      else $error("disabled channel took a write");
   steps_load_a: assert property ((chan_wr && en_q[0] && WR_ADDR == dcr_pkg::DCR_A_FALL && IO_UPDATE)
                                 |=> FALL_STEP[0] == $past(WR_DATA)) // R8
      else $error("falling step not loaded");
   rates_load_a: assert property ((chan_wr && en_q[0] && WR_ADDR == dcr_pkg::DCR_A_SRR && IO_UPDATE)
                                 |=> {FALL_RATE[0], RISE_RATE[0]} == $past(WR_DATA[15:0])) // R6
      else $error("ramp rates not placed");
   open_bits_a: assert property (CFW[0][21:16] == 6'h00 && ACW[0][13] == 1'b0
                                 && AMP_RATE[0] == ACW[0][23:16]) // R12
      else $error("open bits not zero");
   rise_load_a: assert property ((chan_wr && en_q[0] && WR_ADDR == dcr_pkg::DCR_A_RISE && IO_UPDATE)
                                |=> RISE_STEP[0] == $past(WR_DATA)) // R7
      else $error("rising step not loaded");
   pow_mask_a: assert property ((chan_wr && en_q[0] && WR_ADDR == dcr_pkg::DCR_A_POW && IO_UPDATE)
                               |=> POW[0] == $past(WR_DATA[13:0])) // R5
      else $error("phase offset not loaded");

   sel_write_c: cover property (csel_wr ##2 chan_wr ##[1:40] IO_UPDATE);
   clr_pulse_c: cover property (IO_UPDATE ##1 ACC_CLR[0]);
   readback_c:  cover property (RD_STB && is_chan(RD_ADDR) ##1 RD_VALID);
endmodule // dcr_bank

// ### dcr_host.sv
// Purpose: behavioural host controller issuing decoded register cycles to the bank
// Assumes: every request is launched on the falling clock edge and taken at the next rising edge
// Notes:   released address and data lines change, so a stale value is never mistaken for a request
`timescale 1ns/10ps
module dcr_host (
   input  wire logic        clk,
   output logic             wr_stb,
   output logic [4:0]       wr_addr,
   output logic [31:0]      wr_data,
   output logic             rd_stb,
   output logic [4:0]       rd_addr,
   output logic             io_upd
);
   // idle bus at time zero
   initial begin
      wr_stb  = 1'b0;
      wr_addr = 5'h1F;
      wr_data = 32'h0;
      rd_stb  = 1'b0;
      rd_addr = 5'h1F;
      io_upd  = 1'b0;
   end

   // one whole-register write, held across exactly one rising edge
   task automatic wr(input logic [4:0] a, input logic [31:0] d);
      @(negedge clk);
      wr_stb  = 1'b1;
      wr_addr = a;
      wr_data = d;
      @(negedge clk);
      wr_stb  = 1'b0;
      wr_addr = ~a;
      wr_data = ~d;
   endtask

   // one read request; the answer is visible when this returns
   task automatic rd(input logic [4:0] a);
      @(negedge clk);
      rd_stb  = 1'b1;
      rd_addr = a;
      @(negedge clk);
      rd_stb  = 1'b0;
      rd_addr = ~a;
   endtask

   // single-cycle update strobe
   task automatic upd();
      @(negedge clk);
      io_upd = 1'b1;
      @(negedge clk);
      io_upd = 1'b0;
   endtask

   // one write with the update strobe in the same cycle
   task automatic wr_upd(input logic [4:0] a, input logic [31:0] d);
      @(negedge clk);
      wr_stb  = 1'b1;
      wr_addr = a;
      wr_data = d;
      io_upd  = 1'b1;
      @(negedge clk);
      wr_stb  = 1'b0;
      wr_addr = ~a;
      wr_data = ~d;
      io_upd  = 1'b0;
   endtask
endmodule // dcr_host

// ### testbench.sv
// Purpose: self-checking bench for the per-channel register bank
// Assumes: host model drives requests; held and active sets are modelled here
// Notes:   random select masks and register subsets; reads return the lowest enabled channel
`timescale 1ns/10ps
module testbench;
   logic              clk, rst_n, wr_stb, rd_stb, io_upd, rd_valid, lsbf;
   logic [4:0]        wr_addr, rd_addr;
   logic [31:0]       wr_data, rd_data, v;
   logic [3:0]        ch_en, acc_clr, en, ea;
   logic [1:0]        smode;
   logic [2:0]        sm_h, sm_a;
   logic [3:0][23:0]  cfw, acw;
   logic [3:0][31:0]  ftw, rstep, fstep;
   logic [3:0][13:0]  pow;
   logic [3:0][7:0]   arate, rrate, frate;
   logic [31:0]       hm [4][7];
   logic [31:0]       am [4][7];
   int                bad_count, cmp_count, cycles;

   dcr_host dcr_host_i (.clk(clk), .wr_stb(wr_stb), .wr_addr(wr_addr), .wr_data(wr_data),
      .rd_stb(rd_stb), .rd_addr(rd_addr), .io_upd(io_upd));
   dcr_bank #(.NCH(4)) dcr_bank_i (.CLK(clk), .RST_N(rst_n), .WR_STB(wr_stb), .WR_ADDR(wr_addr),
      .WR_DATA(wr_data), .RD_STB(rd_stb), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .RD_VALID(rd_valid),
      .IO_UPDATE(io_upd), .CH_EN(ch_en), .SERIAL_MODE(smode), .LSB_FIRST(lsbf), .CFW(cfw), .FTW(ftw),
      .POW(pow), .ACW(acw), .AMP_RATE(arate), .RISE_RATE(rrate), .FALL_RATE(frate),
      .RISE_STEP(rstep), .FALL_STEP(fstep), .ACC_CLR(acc_clr));

   // 100 MHz clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // hang guard, well above the few hundred cycles the run needs
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         test_done();
      end
   end

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask

   // every active output against the modelled active set
   task automatic chk_all();
      for (int c = 0; c < 4; c++) begin
         chk("cfw", am[c][0], 32'(cfw[c]));
         chk("ftw", am[c][1], ftw[c]);
         chk("pow", am[c][2], 32'(pow[c]));
         chk("acw", am[c][3], 32'(acw[c]));
         chk("amp_rate", 32'(am[c][3][23:16]), 32'(arate[c]));
         chk("ramp", am[c][4], {16'h0, frate[c], rrate[c]});
         chk("rise", am[c][5], rstep[c]);
         chk("fall", am[c][6], fstep[c]);
         chk("acc_clr", 32'(ea[c]), 32'(acc_clr[c]));
      end
      chk("mode", 32'(sm_a), {29'h0, smode, lsbf});
   endtask

   task automatic sel_w(input logic [7:0] s);
      dcr_host_i.wr(5'h00, {24'h0, s});
      en = s[7:4];
      sm_h = s[2:0];
      chk("ch_en", 32'(s[7:4]), 32'(ch_en));
   endtask

   // held copy changes only in enabled channels, open bits dropped
   task automatic wr_m(input logic [2:0] i, input logic [31:0] d);
      dcr_host_i.wr(5'(dcr_pkg::DCR_A_CFW + i), d);
      for (int c = 0; c < 4; c++) if (en[c]) hm[c][i] = d & dcr_pkg::DCR_MASK[i];
   endtask

   task automatic rd_m(input logic [4:0] a);
      logic [31:0] e;
      e = 32'h0;
      for (int c = 3; c >= 0; c--) if (en[c] && a >= 5'h03 && a <= 5'h09) e = hm[c][a - 5'h03];
      if (a == 5'h00) e = {24'h0, en, 1'b0, sm_h};
      dcr_host_i.rd(a);
      chk("rd_valid", 32'h1, 32'(rd_valid));
      chk("rd_data", e, rd_data);
   endtask

   // update copies held to active and clears the held clearing bit
   task automatic upd_m();
      dcr_host_i.upd();
      for (int c = 0; c < 4; c++) begin
         ea[c] = hm[c][0][1];
         hm[c][0][1] = 1'b0;
         am[c] = hm[c];
      end
      sm_a = sm_h;
      chk_all();
   endtask

   // write in the update cycle is included; a clearing bit of 1 written then stays held
   task automatic wu_m(input logic [2:0] i, input logic [31:0] d);
      dcr_host_i.wr_upd(5'(dcr_pkg::DCR_A_CFW + i), d);
      for (int c = 0; c < 4; c++) begin
         if (en[c]) hm[c][i] = d & dcr_pkg::DCR_MASK[i];
         ea[c] = hm[c][0][1];
         am[c] = hm[c];
         am[c][0][1] = 1'b0;
         if (!(en[c] && i == 3'h0 && d[1])) hm[c][0][1] = 1'b0;
      end
      sm_a = sm_h;
      chk_all();
   endtask

   // main sequence: reset, one-channel corner, then random rounds
   initial begin
      bad_count = 0;
      cmp_count = 0;
      rst_n = 1'b0;
      en = 4'hF;
      ea = 4'h0;
      sm_h = 3'h0;
      sm_a = 3'h0;
      void'($urandom(32'h1043));
      for (int c = 0; c < 4; c++) begin
         hm[c] = '{0: 32'h302, default: 32'h0};
         am[c] = hm[c];
      end
      repeat (8) @(negedge clk);
      rst_n = 1'b1;
      chk_all();
      chk("ch_en_rst", 32'hF, 32'(ch_en));
      sel_w(8'h10);
      v = $urandom;
      wr_m(3'h1, v);
      chk("ftw_hold", 32'h0, ftw[0]);
      rd_m(dcr_pkg::DCR_A_FTW);
      upd_m();
      @(negedge clk);
      chk("acc_clr_end", 32'h0, 32'(acc_clr));
      // corner: every word written in its update cycle, clearing bit forced on
      for (int i = 0; i < 7; i++) wu_m(3'(i), $urandom | 32'h2);
      repeat (10) begin
         sel_w(8'($urandom));
         for (int i = 0; i < 7; i++) if ($urandom % 2) wr_m(3'(i), $urandom);
         dcr_host_i.wr(5'h0A, $urandom);
         rd_m(5'($urandom % 11));
         upd_m();
      end
      test_done();
   end
endmodule // testbench
